// ### design/aoc_pkg.sv
/*
 * Package of the output control register bank: register offsets, reset values,
 * field positions, mode codes, serial frame layout and output word layout.
 * Assumes nothing of its surroundings; every design file imports it whole.
 */
package aoc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [1:0] ADDR_DEV_CTRL   = 2'h0;
    localparam logic [1:0] ADDR_PAT_HIGH   = 2'h1;
    localparam logic [1:0] ADDR_PAT_LOW    = 2'h2;
    localparam logic [7:0] RST_DEV_CTRL    = 8'h08;
    localparam logic [7:0] RST_PAT_HIGH    = 8'h00;
    localparam logic [7:0] RST_PAT_LOW     = 8'h00;

    // ------------------------------------------------------------------
    // Device control fields
    // ------------------------------------------------------------------
    localparam int MODE_HI   = 7;
    localparam int MODE_LO   = 6;
    localparam int LANE_BIT  = 5;
    localparam int DCS_BIT   = 4;
    localparam int FMT_BIT   = 3;
    localparam int ALIGN_BIT = 2;
    localparam int PDA_BIT   = 1;
    localparam int PDB_BIT   = 0;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_FIXED  = 2'h1;
    localparam logic [1:0] MODE_USER   = 2'h2;
    localparam logic [1:0] MODE_RSVD   = 2'h3;

    // User pattern fields: high register [5:0], low register [7:2].
    localparam int PATH_HI = 5;
    localparam int PATL_HI = 7;
    localparam int PATL_LO = 2;

    // ------------------------------------------------------------------
    // Serial frame: bit 15 read, bits 9:8 address, bits 7:0 data
    // ------------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] HALF_FRAME = 5'h08;
    localparam int         RW_BIT     = 15;
    localparam int         ADDR_HI    = 9;
    localparam int         ADDR_LO    = 8;

    // ------------------------------------------------------------------
    // Output word
    // ------------------------------------------------------------------
    localparam logic [11:0] FIXED_PATTERN = 12'hA63;
    localparam logic [3:0]  WORD_LAST     = 4'hB;
    localparam logic [3:0]  HALF_WORD     = 4'h6;
    localparam logic [3:0]  HALF_MSB      = 4'h5;

    typedef struct packed {
        logic [1:0] mode;
        logic       single_lane;
        logic       dcs_on;
        logic       twos_comp;
        logic       word_align;
        logic       pd_a;
        logic       pd_b;
    } aoc_ctrl_t;

endpackage : aoc_pkg

// ### design/aoc_serializer.sv
/*
 * Serializer of one channel: a 12-bit word every 12 system clocks, sent on
 * lane one alone or split over lanes one and zero at half the bit rate.
 * Assumes the word input is stable from the cycle its counter wraps.
 */
`timescale 1ns/10ps
`default_nettype none

module aoc_serializer
    import aoc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Configuration and word
    input  wire logic        single_lane,
    input  wire logic        word_align,
    input  wire logic [11:0] word,
    // Serial lanes
    output logic             lane_one,
    output logic             lane_zero,
    output logic             lane_zero_oe,
    output logic             word_start
);

    logic [3:0]  cnt_q, cnt_d;
    logic [11:0] cur_q, cur_d, prev_q, prev_d;
    logic        one_q, one_d, zero_q, zero_d, oe_q, oe_d, st_q, st_d;
    logic [3:0]  c0, i1, i0;

    // ------------------------------------------------------------------
    // Bit selection
    // ------------------------------------------------------------------
    always_comb
    begin
        cnt_d  = (cnt_q == WORD_LAST) ? 4'h0 : cnt_q + 4'h1;
        cur_d  = (cnt_q == WORD_LAST) ? word : cur_q;
        prev_d = (cnt_q == WORD_LAST) ? cur_q : prev_q;
        st_d   = (cnt_q == WORD_LAST);
        c0     = (cnt_q >= HALF_WORD) ? cnt_q - HALF_WORD : cnt_q + HALF_WORD;
        i1     = WORD_LAST - {1'b0, cnt_q[3:1]};
        i0     = word_align ? HALF_MSB - {1'b0, cnt_q[3:1]}
                            : HALF_MSB - {1'b0, c0[3:1]};
        oe_d   = !single_lane;
        // Without alignment the low half of a word runs on into the next word
        // period, so its last three bits come from the word just retired.
        zero_d = single_lane ? 1'b0
               : (word_align || cnt_q >= HALF_WORD) ? cur_q[i0] : prev_q[i0];
        if (single_lane)
        begin
            one_d = cur_q[WORD_LAST - cnt_q];
        end
        else if (word_align)
        begin
            // Lane one runs one word behind, so a word's high half leaves one word period after its low half.
            one_d = prev_q[i1];
        end
        else
        begin
            // Each bit is held two clocks; lane zero lags half a word.
            one_d = cur_q[i1];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q  <= 4'h0;
            cur_q  <= 12'h000;
            prev_q <= 12'h000;
            one_q  <= 1'b0;
            zero_q <= 1'b0;
            oe_q   <= 1'b0;
            st_q   <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            cur_q  <= cur_d;
            prev_q <= prev_d;
            one_q  <= one_d;
            zero_q <= zero_d;
            oe_q   <= oe_d;
            st_q   <= st_d;
        end
    end

    assign lane_one     = one_q;
    assign lane_zero    = zero_q;
    assign lane_zero_oe = oe_q;
    assign word_start   = st_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_single_tristate;
        @(posedge sys_clk) disable iff (!rst_b)
        single_lane |=> !lane_zero_oe && !lane_zero;
    endproperty
    a_single_tristate: assert property (p_single_tristate)
        else $error("lane zero driven in single-lane mode");

    property p_dual_half_rate;
        @(posedge sys_clk) disable iff (!rst_b)
        (!single_lane && !word_align && cnt_q[0] == 1'b0) ##1 (!single_lane && !word_align)
            |=> $stable(lane_one);
    endproperty
    a_dual_half_rate: assert property (p_dual_half_rate)
        else $error("dual-lane bit not held for two clocks");

endmodule : aoc_serializer

`default_nettype wire

// ### design/aoc_ctrl_regs.sv
/*
 * Output control register bank with its four-wire serial port, pin-strap
 * override and the word selection for two serialized channels.
 * Assumes the serial pins and straps are asynchronous to sys_clk and that
 * serial clock periods span several sys_clk periods.
 */
`timescale 1ns/10ps
`default_nettype none

module aoc_ctrl_regs
    import aoc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Serial control port
    input  wire logic        serial_select_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_din,
    output logic             serial_dout,
    output logic             serial_dout_oe,
    // Pin straps
    input  wire logic        serial_enable,
    input  wire logic        strap_test,
    input  wire logic        strap_single_lane,
    input  wire logic        strap_dcs_on,
    input  wire logic        strap_word_align,
    input  wire logic        strap_pd_a,
    input  wire logic        strap_pd_b,
    // Converter samples, offset binary
    input  wire logic [10:0] sample_a,
    input  wire logic [10:0] sample_b,
    // Effective control
    output var aoc_ctrl_t    ctrl,
    // Serial data lanes
    output logic             serial_lane_one_a,
    output logic             serial_lane_zero_a,
    output logic             serial_lane_zero_a_oe,
    output logic             serial_lane_one_b,
    output logic             serial_lane_zero_b,
    output logic             serial_lane_zero_b_oe,
    output logic             word_start
);

    // ------------------------------------------------------------------
    // Input synchronizers
    // ------------------------------------------------------------------
    // Order: select, clock, data, enable, six straps.
    logic [9:0] pin_raw, s1_q, s2_q;
    logic [9:0] s1_d, s2_d;
    logic       sclk_old_q, sel_old_q, sclk_old_d, sel_old_d;

    assign pin_raw = {serial_select_n, serial_clk, serial_din, serial_enable,
                      strap_test, strap_single_lane, strap_dcs_on,
                      strap_word_align, strap_pd_a, strap_pd_b};

    always_comb
    begin
        s1_d       = pin_raw;
        s2_d       = s1_q;
        sclk_old_d = s2_q[8];
        sel_old_d  = s2_q[9];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q       <= 10'h200;
            s2_q       <= 10'h200;
            sclk_old_q <= 1'b0;
            sel_old_q  <= 1'b1;
        end
        else
        begin
            s1_q       <= s1_d;
            s2_q       <= s2_d;
            sclk_old_q <= sclk_old_d;
            sel_old_q  <= sel_old_d;
        end
    end

    logic sel_n, sclk_rise, sclk_fall, sel_rise;
    assign sel_n     = s2_q[9];
    assign sclk_rise = s2_q[8] && !sclk_old_q;
    assign sclk_fall = !s2_q[8] && sclk_old_q;
    assign sel_rise  = sel_n && !sel_old_q;

    // ------------------------------------------------------------------
    // Serial frame engine and registers
    // ------------------------------------------------------------------
    logic [15:0] shift_q, shift_d;
    logic [4:0]  bits_q, bits_d;
    logic [7:0]  rd_q, rd_d;
    logic        dout_q, dout_d;
    logic [1:0]  addr_q, addr_d;
    logic [7:0]  dev_ctrl_q, dev_ctrl_d;
    logic [7:0]  pat_high_q, pat_high_d;
    logic [7:0]  pat_low_q, pat_low_d;
    logic [7:0]  rd_sel;
    logic [1:0]  shift_addr;

    assign shift_addr = shift_q[ADDR_HI:ADDR_LO];

    always_comb
    begin
        // At the eighth rising edge the address is the last bit shifted in
        // and the bit now on the data line.
        case ({shift_q[0], s2_q[7]})
            ADDR_DEV_CTRL: rd_sel = dev_ctrl_q;
            ADDR_PAT_HIGH: rd_sel = pat_high_q;
            ADDR_PAT_LOW:  rd_sel = pat_low_q;
            default:       rd_sel = 8'h00;
        endcase
    end

    always_comb
    begin
        shift_d    = shift_q;
        bits_d     = bits_q;
        rd_d       = rd_q;
        dout_d     = dout_q;
        addr_d     = addr_q;
        dev_ctrl_d = dev_ctrl_q;
        pat_high_d = pat_high_q;
        pat_low_d  = pat_low_q;
        if (sel_n)
        begin
            bits_d = 5'h00;
            dout_d = 1'b0;
        end
        else
        begin
            if (sclk_rise && bits_q != FRAME_BITS)
            begin
                shift_d = {shift_q[14:0], s2_q[7]};
                bits_d  = bits_q + 5'h01;
                if (bits_q == HALF_FRAME - 5'h01)
                begin
                    // Address sits in the low bits of the first byte here.
                    rd_d = rd_sel;
                end
            end
            if (sclk_fall && bits_q >= HALF_FRAME)
            begin
                dout_d = rd_q[7];
                rd_d   = {rd_q[6:0], 1'b0};
            end
        end
        // A frame cut short leaves address and registers untouched.
        if (sel_rise && bits_q == FRAME_BITS)
        begin
            addr_d = shift_addr;
            if (!shift_q[RW_BIT])
            begin
                case (shift_addr)
                    ADDR_DEV_CTRL: dev_ctrl_d = shift_q[7:0];
                    ADDR_PAT_HIGH: pat_high_d = shift_q[7:0];
                    ADDR_PAT_LOW:  pat_low_d  = shift_q[7:0];
                    default:       dev_ctrl_d = dev_ctrl_q;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_q    <= 16'h0000;
            bits_q     <= 5'h00;
            rd_q       <= 8'h00;
            dout_q     <= 1'b0;
            addr_q     <= 2'h0;
            dev_ctrl_q <= RST_DEV_CTRL;
            pat_high_q <= RST_PAT_HIGH;
            pat_low_q  <= RST_PAT_LOW;
        end
        else
        begin
            shift_q    <= shift_d;
            bits_q     <= bits_d;
            rd_q       <= rd_d;
            dout_q     <= dout_d;
            addr_q     <= addr_d;
            dev_ctrl_q <= dev_ctrl_d;
            pat_high_q <= pat_high_d;
            pat_low_q  <= pat_low_d;
        end
    end

    assign serial_dout    = dout_q;
    assign serial_dout_oe = !sel_n;

    // ------------------------------------------------------------------
    // Effective control and word selection
    // ------------------------------------------------------------------
    logic [11:0] word_a, word_b, user_word;

    function automatic logic [11:0] pick_word(input aoc_ctrl_t c,
                                              input logic pd,
                                              input logic [10:0] s,
                                              input logic [11:0] u);
        logic [11:0] w;
        w = 12'h000;
        case (c.mode)
            MODE_NORMAL: w = pd ? 12'h000 : {s[10] ^ c.twos_comp, s[9:0], 1'b0};
            MODE_FIXED:  w = FIXED_PATTERN;
            MODE_USER:   w = u;
            default:     w = 12'h000;
        endcase
        return w;
    endfunction : pick_word

    always_comb
    begin
        if (s2_q[6])
        begin
            ctrl.mode        = dev_ctrl_q[MODE_HI:MODE_LO];
            ctrl.single_lane = dev_ctrl_q[LANE_BIT];
            ctrl.dcs_on      = dev_ctrl_q[DCS_BIT];
            ctrl.twos_comp   = dev_ctrl_q[FMT_BIT];
            ctrl.word_align  = dev_ctrl_q[ALIGN_BIT];
            ctrl.pd_a        = dev_ctrl_q[PDA_BIT];
            ctrl.pd_b        = dev_ctrl_q[PDB_BIT];
        end
        else
        begin
            ctrl.mode        = s2_q[5] ? MODE_FIXED : MODE_NORMAL;
            ctrl.single_lane = s2_q[4];
            ctrl.dcs_on      = s2_q[3];
            ctrl.twos_comp   = s2_q[3];
            ctrl.word_align  = s2_q[2];
            ctrl.pd_a        = s2_q[1];
            ctrl.pd_b        = s2_q[0];
        end
        user_word = {pat_high_q[PATH_HI:0], pat_low_q[PATL_HI:PATL_LO]};
        word_a    = pick_word(ctrl, ctrl.pd_a, sample_a, user_word);
        word_b    = pick_word(ctrl, ctrl.pd_b, sample_b, user_word);
    end

    // ------------------------------------------------------------------
    // Serializers
    // ------------------------------------------------------------------
    aoc_serializer u_ser_a (
        .sys_clk      (sys_clk),
        .rst_b        (rst_b),
        .single_lane  (ctrl.single_lane),
        .word_align   (ctrl.word_align),
        .word         (word_a),
        .lane_one     (serial_lane_one_a),
        .lane_zero    (serial_lane_zero_a),
        .lane_zero_oe (serial_lane_zero_a_oe),
        .word_start   (word_start)
    );

    aoc_serializer u_ser_b (
        .sys_clk      (sys_clk),
        .rst_b        (rst_b),
        .single_lane  (ctrl.single_lane),
        .word_align   (ctrl.word_align),
        .word         (word_b),
        .lane_one     (serial_lane_one_b),
        .lane_zero    (serial_lane_zero_b),
        .lane_zero_oe (serial_lane_zero_b_oe),
        .word_start   ()
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_short_frame;
        @(posedge sys_clk) disable iff (!rst_b)
        (sel_rise && bits_q != FRAME_BITS) |=> $stable(dev_ctrl_q) && $stable(pat_low_q);
    endproperty
    a_short_frame: assert property (p_short_frame)
        else $error("register changed on a short frame");

    property p_full_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (sel_rise && bits_q == FRAME_BITS && !shift_q[RW_BIT] && shift_addr == ADDR_DEV_CTRL)
            |=> dev_ctrl_q == $past(shift_q[7:0]);
    endproperty
    a_full_write: assert property (p_full_write)
        else $error("complete write frame not stored");

    property p_strap_ignored;
        @(posedge sys_clk) disable iff (!rst_b)
        s2_q[6] |-> ctrl.pd_a == dev_ctrl_q[PDA_BIT] && ctrl.mode == dev_ctrl_q[MODE_HI:MODE_LO];
    endproperty
    a_strap_ignored: assert property (p_strap_ignored)
        else $error("strap overrides register while serial enabled");

    property p_fixed_word;
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl.mode == MODE_FIXED |-> word_a == FIXED_PATTERN && word_b == FIXED_PATTERN;
    endproperty
    a_fixed_word: assert property (p_fixed_word)
        else $error("fixed pattern not selected");

    property p_user_word;
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl.mode == MODE_USER |-> word_a[11:6] == pat_high_q[5:0] && word_a[5:0] == pat_low_q[7:2];
    endproperty
    a_user_word: assert property (p_user_word)
        else $error("user pattern word wrong");

    property p_format;
        @(posedge sys_clk) disable iff (!rst_b)
        (ctrl.mode == MODE_NORMAL && !ctrl.pd_a) |-> word_a[11] == (sample_a[10] ^ ctrl.twos_comp);
    endproperty
    a_format: assert property (p_format)
        else $error("output format bit not applied");

    property p_powerdown;
        @(posedge sys_clk) disable iff (!rst_b)
        (ctrl.mode == MODE_NORMAL && ctrl.pd_b) |-> word_b == 12'h000;
    endproperty
    a_powerdown: assert property (p_powerdown)
        else $error("powered-down channel still outputs data");

    property p_lsb_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl.mode == MODE_NORMAL |-> !word_a[0] && !word_b[0];
    endproperty
    a_lsb_zero: assert property (p_lsb_zero)
        else $error("normal word LSB not zero");

endmodule : aoc_ctrl_regs

`default_nettype wire

// ### test/aoc_host_model.sv
/*
 * Host model for the four-wire serial control port of the output control bank.
 * Assumes a 40 MHz sys_clk; the serial clock period is 8 sys_clk, 200 ns.
 */
`timescale 1ns/10ps
`default_nettype none

module aoc_host_model
(
    // Clock
    input  wire logic sys_clk,
    // Serial control port
    output logic      serial_select_n,
    output logic      serial_clk,
    output logic      serial_din,
    input  wire logic serial_dout
);
    // ------------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------------
    initial
    begin
        serial_select_n = 1'b1;
        serial_clk      = 1'b0;
        serial_din      = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold

    // A frame shorter than sixteen clocks is only sent to be refused.
    task automatic xfer(input logic [15:0] frame, input int nclk, output logic [7:0] rdata);
        rdata = 8'h00;
        @(posedge sys_clk);
        serial_select_n <= 1'b0;
        for (int i = 0; i < nclk; i++)
        begin
            hold(1);
            serial_din <= frame[15 - i];
            hold(3);
            if (i >= 8)
            begin
                rdata = {rdata[6:0], serial_dout};
            end
            serial_clk <= 1'b1;
            hold(4);
            serial_clk <= 1'b0;
        end
        hold(4);
        serial_select_n <= 1'b1;
        // The released data line shows the inverse of its last bit.
        serial_din      <= ~serial_din;
        hold(8);
    endtask : xfer
endmodule : aoc_host_model

`default_nettype wire

// ### test/adc_output_control_registers_tb.sv
/*
 * Testbench of the output control register bank: register access, refused
 * frames, output modes, power-down, lane setup and strap override.
 * Assumes the host model drives the serial port.
 */
`timescale 1ns/10ps
`default_nettype none

module adc_output_control_registers_tb;
    import aoc_pkg::*;

    logic        sys_clk, rst_b, sel_n, sclk, sdin, sdout, sdout_oe, word_start;
    logic        serial_enable, st_test, st_single, st_dcs, st_align, st_pda, st_pdb;
    logic [10:0] sample_a, sample_b;
    aoc_ctrl_t   ctrl;
    logic        l1a, l0a, l0a_oe, l1b, l0b, l0b_oe;
    int          failures, comparisons;

    aoc_host_model i_host (.sys_clk(sys_clk), .serial_select_n(sel_n), .serial_clk(sclk),
        .serial_din(sdin), .serial_dout(sdout));

    aoc_ctrl_regs i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .serial_select_n(sel_n),
        .serial_clk(sclk), .serial_din(sdin), .serial_dout(sdout), .serial_dout_oe(sdout_oe),
        .serial_enable(serial_enable), .strap_test(st_test), .strap_single_lane(st_single),
        .strap_dcs_on(st_dcs), .strap_word_align(st_align), .strap_pd_a(st_pda),
        .strap_pd_b(st_pdb), .sample_a(sample_a), .sample_b(sample_b), .ctrl(ctrl),
        .serial_lane_one_a(l1a), .serial_lane_zero_a(l0a), .serial_lane_zero_a_oe(l0a_oe),
        .serial_lane_one_b(l1b), .serial_lane_zero_b(l0b), .serial_lane_zero_b_oe(l0b_oe),
        .word_start(word_start));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_host.xfer({6'h00, a, d}, 16, r);
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        i_host.xfer({6'h20, a, 8'h00}, 16, d);
    endtask : rd

    // Skips one word so that a word latched before a change is not judged.
    task automatic grab(output logic [11:0] wa, output logic [11:0] wb);
        int seen;
        int n;
        seen = 0;
        n = 0;
        while (seen < 2 && n < 60)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (word_start === 1'b1)
                seen++;
        end
        if (seen < 2)
        begin
            failures++;
            wrap_up();
        end
        // Bit 11 leaves in the cycle after the word start pulse.
        for (int i = 0; i < 12; i++)
        begin
            @(posedge sys_clk);
            #1;
            wa = {wa[10:0], l1a};
            wb = {wb[10:0], l1b};
        end
    endtask : grab

    // Changes sample A after a word starts, so a lane taken from the wrong
    // word shows the new sample in its half.
    task automatic grab_dual(input logic align, input logic [10:0] nxt, output logic [11:0] wa);
        logic [5:0] hi, lo;
        int         n;
        n = 0;
        hi = 6'h00;
        lo = 6'h00;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (word_start !== 1'b1 && n < 30);
        if (word_start !== 1'b1)
        begin
            failures++;
            wrap_up();
        end
        @(posedge sys_clk);
        sample_a <= nxt;
        for (int k = 1; k < 24; k++)
        begin
            #1;
            if (k % 2 == 1)
            begin
                if (align ? k > 12 : k < 12)
                    hi = {hi[4:0], l1a};
                if (align ? k < 12 : (k > 6 && k < 18))
                    lo = {lo[4:0], l0a};
            end
            @(posedge sys_clk);
        end
        wa = {hi, lo};
    endtask : grab_dual

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] d;
        rd(ADDR_DEV_CTRL, d);
        cmp({4'h0, d}, 12'h008);
        rd(ADDR_PAT_HIGH, d);
        cmp({4'h0, d}, 12'h000);
        wr(ADDR_PAT_HIGH, 8'h2A);
        wr(ADDR_PAT_LOW, 8'hB4);
        wr(2'h3, 8'hFF);
        rd(ADDR_PAT_HIGH, d);
        cmp({4'h0, d}, 12'h02A);
        rd(ADDR_PAT_LOW, d);
        cmp({4'h0, d}, 12'h0B4);
        rd(2'h3, d);
        cmp({4'h0, d}, 12'h000);
        i_host.xfer({6'h00, ADDR_DEV_CTRL, 8'h20}, 10, d);
        rd(ADDR_DEV_CTRL, d);
        cmp({4'h0, d}, 12'h008);
    endtask : t_regs

    task automatic t_modes();
        logic [7:0]  regv [6] = '{8'h20, 8'h28, 8'h22, 8'h21, 8'h60, 8'hA0};
        logic [11:0] ea   [6] = '{12'hAAA, 12'h2AA, 12'h000, 12'hAAA, 12'hA63, 12'hAAD};
        logic [11:0] eb   [6] = '{12'h556, 12'hD56, 12'h556, 12'h000, 12'hA63, 12'hAAD};
        logic [11:0] wa, wb;
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_DEV_CTRL, regv[i]);
            grab(wa, wb);
            cmp(wa, ea[i]);
            cmp(wb, eb[i]);
            cmp({10'h000, l0a_oe, l0b_oe}, 12'h000);
        end
    endtask : t_modes

    task automatic t_ctrl();
        wr(ADDR_DEV_CTRL, 8'h38);
        cmp({4'h0, ctrl}, {4'h0, MODE_NORMAL, 6'b111000});
        st_test <= 1'b1;
        i_host.hold(8);
        cmp({10'h000, ctrl.mode}, {10'h000, MODE_NORMAL});
        serial_enable <= 1'b0;
        i_host.hold(8);
        cmp({10'h000, ctrl.mode}, {10'h000, MODE_FIXED});
        {st_single, st_dcs, st_align, st_pda, st_pdb} <= 5'b01111;
        i_host.hold(8);
        cmp({4'h0, ctrl}, {4'h0, MODE_FIXED, 6'b011111});
        {st_single, st_dcs, st_align, st_pda, st_pdb} <= 5'b10000;
        i_host.hold(8);
        cmp({4'h0, ctrl}, {4'h0, MODE_FIXED, 6'b100000});
        serial_enable <= 1'b1;
        st_test <= 1'b0;
        i_host.hold(8);
    endtask : t_ctrl

    task automatic t_dual();
        logic [11:0] w;
        wr(ADDR_DEV_CTRL, 8'h00);
        i_host.hold(30);
        cmp({10'h000, l0a_oe, l0b_oe}, 12'h003);
        grab_dual(1'b0, 11'h0F0, w);
        cmp(w, 12'hAAA);
        wr(ADDR_DEV_CTRL, 8'h04);
        i_host.hold(30);
        cmp({10'h000, l0a_oe, l0b_oe}, 12'h003);
        grab_dual(1'b1, 11'h555, w);
        cmp(w, 12'h1E0);
    endtask : t_dual

    // ------------------------------------------------------------------
    // Clock, reset and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        failures = 0;
        comparisons = 0;
        rst_b = 1'b0;
        serial_enable = 1'b1;
        {st_test, st_single, st_dcs, st_align, st_pda, st_pdb} = 6'h00;
        sample_a = 11'h555;
        sample_b = 11'h2AB;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        i_host.hold(4);
        t_regs();
        t_modes();
        t_ctrl();
        t_dual();
        wrap_up();
    end
endmodule : adc_output_control_registers_tb

`default_nettype wire
